//--- hdl/aesr_pkg.sv
// Purpose: Shared constants for the absolute encoder serial readout block
// Assumes: Pin inputs are already digitized comparator levels
// Notes: Position word is D11..D1, sine bit, interpolated bit, MSB at top
package aesr_pkg;
    localparam int POS_W = 13;
    localparam int TRK_W = 11;
    localparam int GRAY_W = 12;
    // Field positions inside the position word
    localparam int POS_MSB = 12;
    localparam int POS_TRK_LO = 2;
    localparam int POS_SIN = 1;
    localparam int POS_LSB = 0;
    // Synchronised pin bundle: tracks, sine, cosine, lsb, fix, invert, led fault
    localparam int PIN_W = 17;
    localparam int PIN_SIN = 11;
    localparam int PIN_COS = 12;
    localparam int PIN_LSB = 13;
    localparam int PIN_FIX = 14;
    localparam int PIN_INV = 15;
    localparam int PIN_LED = 16;
    // Link and encoder limits; neither the logic nor the master model reads or keeps them
    localparam int SCL_MAX_MHZ = 16;
    localparam int WORD_TIME_NS = 1000;
    localparam int QUAD_CPR = 1024;
    localparam int RPM_MAX = 12000;
    // Reset and saturation values
    localparam logic [POS_W-1:0] POS_RST = 13'h0000;
    localparam logic [TRK_W-1:0] TRK_RST = 11'h000;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_SAT = 4'hf;
endpackage : aesr_pkg

//--- hdl/aesr_sync.sv
// Purpose: Two-flop synchroniser for a bundle of independent levels
// Assumes: Each bit is a level with no relation to its neighbours
// Notes: Only the second flop is visible outside
`timescale 1ns/100ps
module aesr_sync #(
    parameter int W = 1
) (
    input wire logic clk, // Destination clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [W-1:0] d, // Asynchronous levels
    output logic [W-1:0] q // Synchronised levels
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : aesr_sync

//--- hdl/aesr_encoder_top.sv
// Purpose: Absolute 13-bit Gray position build and synchronous-serial readout
// Assumes: Master drives load select and cascade input in the shift clock domain
// Notes: Position is taken to the link domain by a toggle handshake
// Contract
// - Build 13-bit position from eleven tracks, sine bit and interpolated bit, synchronised.
// - With correction on, track switching points follow sine and cosine bits.
// - Correction touches only the upper eleven bits, never the interpolated bit.
// - Correction enable input high turns correction on, low turns it off.
// - Serial output always presents the most significant bit first.
// - Direction invert high inverts the most significant position bit.
// - Invert low counts up clockwise; invert high reverses counting direction.
// - Cascade input feeds the shift register toward the serial output.
// - Select high is load mode showing the MSB; low is shift mode.
// - In shift mode the register advances on each shift clock rising edge.
// - LED error output is 1 on error, 0 otherwise.
// - Monotone 12-bit Gray code produced in real time up to 12000 RPM.
// - Quadrature outputs A and B carry 1024 cycles per revolution.
`timescale 1ns/100ps
module aesr_encoder_top (
    input wire logic clock, // System clock, 200 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic [10:0] track_bits, // Digitized tracks D11..D1
    input wire logic sine_digitized_bit, // Digitized sine channel
    input wire logic cosine_digitized_bit, // Digitized cosine channel
    input wire logic interp_bit, // Interpolated least significant bit
    input wire logic gray_fix_enable, // 1 enables switching point correction
    input wire logic direction_invert, // 1 reverses counting direction
    input wire logic led_fault_detect, // Raw LED regulation fault level
    input wire logic ssi_clock, // Shift clock from the master
    input wire logic load_shift_select, // 1 load, 0 shift
    input wire logic cascade_in, // Serial input from a chained encoder
    output logic serial_out, // Serial position output
    output logic quadrature_out_a, // Incremental channel A
    output logic quadrature_out_b, // Incremental channel B
    output logic led_error_flag // LED error, 1 on fault
);
    localparam int TW = aesr_pkg::TRK_W;
    localparam int GW = aesr_pkg::GRAY_W;
    localparam int PW = aesr_pkg::POS_W;

    function automatic logic [GW-1:0] gray_to_bin(input logic [GW-1:0] g);
        logic [GW-1:0] b;
        b[GW-1] = g[GW-1];
        for (int i = GW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin

    function automatic logic [GW-1:0] bin_to_gray(input logic [GW-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin_to_gray

    // Neighbour code one step away that keeps the sine bit: the track bit
    // that switches at a cosine edge, whichever way the wheel turns.
    function automatic logic [TW-1:0] step_tracks(input logic [TW-1:0] t,
                                                  input logic s);
        logic [GW-1:0] b;
        logic [GW-1:0] up;
        logic [GW-1:0] dn;
        b = gray_to_bin({t, s});
        up = bin_to_gray(b + 12'h001);
        dn = bin_to_gray(b - 12'h001);
        if (up[0] == s) begin
            return up[GW-1:1];
        end else begin
            return dn[GW-1:1];
        end
    endfunction : step_tracks

    // ---------------- System clock domain ----------------
    logic [aesr_pkg::PIN_W-1:0] pins_s;
    logic [TW-1:0] trk_s;
    logic sin_s, cos_s, lsb_s, fix_s, inv_s, led_s;
    logic sin_d_r, cos_d_r;
    logic [TW-1:0] fix_trk_r;
    logic [TW-1:0] trk_used;
    logic [PW-1:0] pos_r;
    logic [PW-1:0] hold_r;
    logic req_r;
    logic ack_s;

    aesr_sync #(.W(aesr_pkg::PIN_W)) u_pin_sync (
        .clk(clock),
        .rst(sys_rst),
        .d({led_fault_detect, direction_invert, gray_fix_enable, interp_bit,
            cosine_digitized_bit, sine_digitized_bit, track_bits}),
        .q(pins_s)
    );

    assign trk_s = pins_s[TW-1:0];
    assign sin_s = pins_s[aesr_pkg::PIN_SIN];
    assign cos_s = pins_s[aesr_pkg::PIN_COS];
    assign lsb_s = pins_s[aesr_pkg::PIN_LSB];
    assign fix_s = pins_s[aesr_pkg::PIN_FIX];
    assign inv_s = pins_s[aesr_pkg::PIN_INV];
    assign led_s = pins_s[aesr_pkg::PIN_LED];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sin_d_r <= 1'b0;
            cos_d_r <= 1'b0;
        end else begin
            sin_d_r <= sin_s;
            cos_d_r <= cos_s;
        end
    end

    // Tracks are steady at sine edges, so they are sampled there; the
    // switch itself is placed at the cosine edge, never where a track
    // comparator happens to flip. A sine edge wins if both move together.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fix_trk_r <= aesr_pkg::TRK_RST;
        end else if (sin_s != sin_d_r) begin
            fix_trk_r <= trk_s;
        end else if (cos_s != cos_d_r) begin
            fix_trk_r <= step_tracks(fix_trk_r, sin_s);
        end
    end

    assign trk_used = fix_s ? fix_trk_r : trk_s;

    // All fields update on one edge so the word never mixes two positions.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pos_r <= aesr_pkg::POS_RST;
        end else begin
            pos_r <= {trk_used[TW-1] ^ inv_s, trk_used[TW-2:0], sin_s, lsb_s};
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            quadrature_out_a <= 1'b0;
            quadrature_out_b <= 1'b0;
        end else begin
            quadrature_out_a <= sin_s;
            quadrature_out_b <= cos_s;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            led_error_flag <= 1'b0;
        end else begin
            led_error_flag <= led_s;
        end
    end

    // Hold word changes only once the link side has acknowledged the last
    // one, so the link may read it as a steady bus.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hold_r <= aesr_pkg::POS_RST;
            req_r <= 1'b0;
        end else if (ack_s == req_r) begin
            hold_r <= pos_r;
            req_r <= ~req_r;
        end
    end

    // ---------------- Shift clock domain ----------------
    // The shift clock may stop between frames; a fresh sample reaches the
    // register only after a few load-mode edges.
    logic req_l;
    logic ack_l_r;
    logic [PW-1:0] word_l_r;
    logic [PW-1:0] sr_r;
    logic [3:0] shift_cnt_r;

    aesr_sync #(.W(1)) u_req_sync (
        .clk(ssi_clock),
        .rst(sys_rst),
        .d(req_r),
        .q(req_l)
    );

    aesr_sync #(.W(1)) u_ack_sync (
        .clk(clock),
        .rst(sys_rst),
        .d(ack_l_r),
        .q(ack_s)
    );

    always_ff @(posedge ssi_clock or posedge sys_rst) begin
        if (sys_rst) begin
            word_l_r <= aesr_pkg::POS_RST;
            ack_l_r <= 1'b0;
        end else if (req_l != ack_l_r) begin
            word_l_r <= hold_r;
            ack_l_r <= req_l;
        end
    end

    always_ff @(posedge ssi_clock or posedge sys_rst) begin
        if (sys_rst) begin
            sr_r <= aesr_pkg::POS_RST;
        end else if (load_shift_select) begin
            sr_r <= word_l_r;
        end else begin
            sr_r <= {sr_r[PW-2:0], cascade_in};
        end
    end

    assign serial_out = sr_r[aesr_pkg::POS_MSB];

    // Consecutive shift edges, read only by the checks below
    always_ff @(posedge ssi_clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_cnt_r <= aesr_pkg::CNT_RST;
        end else if (load_shift_select) begin
            shift_cnt_r <= aesr_pkg::CNT_RST;
        end else if (shift_cnt_r != aesr_pkg::CNT_SAT) begin
            shift_cnt_r <= shift_cnt_r + 4'h1;
        end
    end

    // ---------------- Checks ----------------
    property p_pos_build;
        @(posedge clock) disable iff (sys_rst)
        1'b1 |=> pos_r[aesr_pkg::POS_SIN:aesr_pkg::POS_LSB] == {$past(sin_s), $past(lsb_s)};
    endproperty
    a_pos_build: assert property (p_pos_build) else $error("low position bits wrong");

    property p_lsb_untouched;
        @(posedge clock) disable iff (sys_rst)
        fix_s |=> pos_r[aesr_pkg::POS_LSB] == $past(lsb_s);
    endproperty
    a_lsb_untouched: assert property (p_lsb_untouched) else $error("lsb altered");

    property p_fix_off;
        @(posedge clock) disable iff (sys_rst)
        !fix_s |=> pos_r[PW-2:aesr_pkg::POS_TRK_LO] == $past(trk_s[TW-2:0]);
    endproperty
    a_fix_off: assert property (p_fix_off) else $error("raw tracks not passed");

    sequence s_sine_edge;
        sin_s != sin_d_r;
    endsequence

    property p_fix_sample;
        @(posedge clock) disable iff (sys_rst)
        (fix_s and s_sine_edge) ##1 fix_s |=> pos_r[PW-2:aesr_pkg::POS_TRK_LO]
            == $past(trk_s[TW-2:0], 2);
    endproperty
    a_fix_sample: assert property (p_fix_sample) else $error("tracks not aligned");

    property p_invert;
        @(posedge clock) disable iff (sys_rst)
        (inv_s && !fix_s) |=> pos_r[aesr_pkg::POS_MSB] != $past(trk_s[TW-1]);
    endproperty
    a_invert: assert property (p_invert) else $error("msb not inverted");

    property p_led;
        @(posedge clock) disable iff (sys_rst)
        $changed(led_s) |=> led_error_flag == $past(led_s);
    endproperty
    a_led: assert property (p_led) else $error("led error flag wrong");

    property p_quad;
        @(posedge clock) disable iff (sys_rst)
        1'b1 |=> quadrature_out_a == $past(sin_s) && quadrature_out_b == $past(cos_s);
    endproperty
    a_quad: assert property (p_quad) else $error("quadrature outputs wrong");

    property p_hold_steady;
        @(posedge clock) disable iff (sys_rst)
        $changed(hold_r) |-> $changed(req_r);
    endproperty
    a_hold_steady: assert property (p_hold_steady) else $error("hold word moved");

    property p_load;
        @(posedge ssi_clock) disable iff (sys_rst)
        load_shift_select |=> sr_r == $past(word_l_r) && serial_out == $past(word_l_r[PW-1]);
    endproperty
    a_load: assert property (p_load) else $error("load did not capture word");

    // Each shift edge moves the next bit up to the output
    property p_shift_step;
        @(posedge ssi_clock) disable iff (sys_rst)
        !load_shift_select |=> serial_out == $past(sr_r[PW-2]);
    endproperty
    a_shift_step: assert property (p_shift_step) else $error("shift step wrong");

    sequence s_load_then_shift;
        load_shift_select ##1 !load_shift_select;
    endsequence

    property p_msb_first;
        @(posedge ssi_clock) disable iff (sys_rst)
        s_load_then_shift |=> serial_out == $past(word_l_r[PW-2], 2);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("second bit wrong");

    property p_cascade;
        @(posedge ssi_clock) disable iff (sys_rst)
        (shift_cnt_r >= 4'hd) |-> serial_out == $past(cascade_in, 13);
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade bit out of order");
endmodule : aesr_encoder_top

//--- testbench/aesr_ssi_master.sv
// Purpose: Synchronous-serial master model that reads the encoder word
// Assumes: Shift clock idles high and only runs inside a frame
// Notes: Frame is 10 load edges then 17 shift edges, the last 4 return cascade bits
`timescale 1ns/100ps
module aesr_ssi_master (
    output logic ssi_clock, // Shift clock
    output logic load_shift_select, // 1 load, 0 shift
    output logic cascade_in, // Bits fed in behind the word
    input wire logic serial_out // Serial word from the encoder
);
    initial begin
        ssi_clock = 1'b1;
        load_shift_select = 1'b1;
        cascade_in = 1'b0;
    end

    // Ten load edges cover the position handshake into the link domain
    task automatic frame(input int half, input logic [3:0] casc, output logic [16:0] got);
        for (int i = 0; i < 27; i++) begin
            ssi_clock = 1'b0;
            #(half);
            if (i >= 10)
                got[26-i] = serial_out;
            ssi_clock = 1'b1;
            #1;
            load_shift_select = (i < 9) || (i == 26);
            if (i >= 9 && i < 13)
                cascade_in = casc[12-i];
            else
                cascade_in = ~cascade_in;
            #(half - 1);
        end
    endtask : frame
endmodule : aesr_ssi_master

//--- testbench/tb.sv
// Purpose: Self-checking bench for position build and serial readout
// Assumes: Master model makes the link clock, still between frames
// Notes: Most frames run fast to keep the run short; one runs at pin speed
`timescale 1ns/100ps
module tb;
    logic clock;
    logic sys_rst;
    logic [10:0] track_bits;
    logic sine_digitized_bit;
    logic cosine_digitized_bit;
    logic interp_bit;
    logic gray_fix_enable;
    logic direction_invert;
    logic led_fault_detect;
    logic ssi_clock;
    logic load_shift_select;
    logic cascade_in;
    logic serial_out;
    logic quadrature_out_a;
    logic quadrature_out_b;
    logic led_error_flag;
    int n_mismatch;
    int total_checks;
    logic [16:0] got;

    always #2.5 clock = ~clock;

    aesr_encoder_top dut (
        .clock(clock),
        .sys_rst(sys_rst),
        .track_bits(track_bits),
        .sine_digitized_bit(sine_digitized_bit),
        .cosine_digitized_bit(cosine_digitized_bit),
        .interp_bit(interp_bit),
        .gray_fix_enable(gray_fix_enable),
        .direction_invert(direction_invert),
        .led_fault_detect(led_fault_detect),
        .ssi_clock(ssi_clock),
        .load_shift_select(load_shift_select),
        .cascade_in(cascade_in),
        .serial_out(serial_out),
        .quadrature_out_a(quadrature_out_a),
        .quadrature_out_b(quadrature_out_b),
        .led_error_flag(led_error_flag)
    );

    aesr_ssi_master master (
        .ssi_clock(ssi_clock),
        .load_shift_select(load_shift_select),
        .cascade_in(cascade_in),
        .serial_out(serial_out)
    );

    function automatic logic [12:0] gray(input logic [12:0] n);
        return n ^ (n >> 1);
    endfunction : gray

    function automatic logic [12:0] g2b(input logic [12:0] g);
        logic [12:0] b;
        b[12] = g[12];
        for (int i = 11; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        return b;
    endfunction : g2b

    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // Word is {tracks, sine, interp}; waits well past the 3 edge input pipeline
    task automatic pins(input logic [12:0] w, input logic fix, input logic inv);
        @(posedge clock);
        #1;
        {track_bits, sine_digitized_bit, interp_bit} = w;
        gray_fix_enable = fix;
        direction_invert = inv;
        repeat (10) @(posedge clock);
    endtask : pins

    task automatic t_word();
        pins(13'h16cf, 1'b0, 1'b0);
        master.frame(6, 4'ha, got);
        check("word", got, {13'h16cf, 4'ha});
        pins(13'h1ffe, 1'b0, 1'b0);
        master.frame(32, 4'h5, got);
        check("slow word", got, {13'h1ffe, 4'h5});
        $display("test word done");
    endtask : t_word

    task automatic t_dir();
        logic [12:0] w0;
        logic [12:0] n;
        for (int k = 0; k < 4; k++) begin
            n = k[1] ? 13'h1ffe : 13'h04d2;
            pins(gray(n), 1'b0, k[0]);
            master.frame(6, 4'h0, got);
            w0 = got[16:4];
            check("msb invert", {4'h0, w0}, {4'h0, gray(n) ^ {k[0], 12'h000}});
            pins(gray(n + 13'h0001), 1'b0, k[0]);
            master.frame(6, 4'h0, got);
            check("direction", {4'h0, g2b(got[16:4]) - g2b(w0)}, k[0] ? 17'h01fff : 17'h00001);
        end
        $display("test direction done");
    endtask : t_dir

    task automatic t_quad();
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            #1;
            {led_fault_detect, cosine_digitized_bit, sine_digitized_bit} = k[2:0];
            repeat (4) @(posedge clock);
            check("quad led", {14'h0, led_error_flag, quadrature_out_b, quadrature_out_a}, {14'h0, k[2:0]});
        end
        $display("test quadrature led done");
    endtask : t_quad

    task automatic t_fix();
        logic [12:0] g;
        logic [12:0] b;
        logic [12:0] n;
        pins({11'h2c4, 2'b00}, 1'b1, 1'b0);
        pins({11'h2c4, 2'b10}, 1'b1, 1'b0);
        pins({11'h7ff, 2'b11}, 1'b1, 1'b0);
        master.frame(6, 4'h3, got);
        check("fix holds", got, {11'h2c4, 2'b11, 4'h3});
        pins({11'h7ff, 2'b11}, 1'b0, 1'b0);
        master.frame(6, 4'h3, got);
        check("fix off", got, {11'h7ff, 2'b11, 4'h3});
        pins({11'h2c4, 2'b00}, 1'b1, 1'b0);
        @(posedge clock);
        #1;
        cosine_digitized_bit = ~cosine_digitized_bit;
        repeat (10) @(posedge clock);
        // The Gray neighbour that keeps the sine bit
        // Twelve-bit code is {tracks, sine}; the spare top bit stays clear
        b = g2b({1'b0, 11'h2c4, 1'b0});
        n = (gray(b + 13'h0001) & 13'h0001) ? b - 13'h0001 : b + 13'h0001;
        g = gray(n);
        master.frame(6, 4'h0, got);
        check("cos step", got, {g[11:1], 2'b00, 4'h0});
        $display("test correction done");
    endtask : t_fix

    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        {track_bits, sine_digitized_bit, cosine_digitized_bit, interp_bit} = 14'h0000;
        {gray_fix_enable, direction_invert, led_fault_detect} = 3'h0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (20) @(posedge clock);
        check("reset", {13'h0, serial_out, quadrature_out_a, quadrature_out_b, led_error_flag}, 17'h0);
        #1;
        sys_rst = 1'b0;
        t_word();
        t_dir();
        t_quad();
        t_fix();
        results();
    end

    initial begin
        #60000;
        n_mismatch++;
        $display("watchdog expired");
        results();
    end
endmodule : tb
